// File: dv/modem_model.sv
// Partner model: a modem driving the four active-low handshake lines
`timescale 1ns/100ps
module modem_model import modem_status_pkg::*; (
   output modem_status_pkg::modem_lines_s modem_n
);
   // Idle modem keeps every line deasserted (high)
   initial modem_n = LINES_IDLE;
   // Index follows the change flag order: cts, dsr, ri, dcd
   task set_line(input int idx, input logic lvl);
      modem_n[idx] <= lvl;
   endtask : set_line
endmodule : modem_model

// File: dv/modem_status_inputs_chk.sv
// Checker: modem line levels, change flags and read clearing
`timescale 1ns/100ps
module modem_status_inputs_chk import modem_status_pkg::*; (
   input wire logic         hclk,
   input wire logic         hresetn,
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic         hready,
   input wire logic [31:0]  hrdata,
   input wire modem_lines_s modem_n,
   input wire logic         irq
);
   logic [3:0] prev_reg;
   logic [2:0] quiet_reg;
   wire rd0 = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_MODEM_STATUS;
   wire rd8 = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_IRQ_STATUS;
   // Edges the lines held still; the synchroniser needs several to settle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_reg  <= LINES_IDLE;
         quiet_reg <= 3'h0;
      end else begin
         prev_reg  <= modem_n;
         quiet_reg <= (modem_n != prev_reg) ? 3'h0 : quiet_reg + 3'(quiet_reg != 3'h7);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property lvl_p(logic p, int b);
      rd0 && quiet_reg == 3'h7 |=> hrdata[b] == !$past(p);
   endproperty
   // Fixed spacing keeps an earlier clearing read out of the window
   property flag_p(logic p, int b);
      (!p)[*2] ##1 p ##1 (p && !rd0)[*7] ##1 rd0 |=> hrdata[b];
   endproperty
   dsr_level_a: assert property (lvl_p(modem_n.data_set_ready_n, 5)) else $error("dsr lvl");
   dcd_level_a: assert property (lvl_p(modem_n.carrier_detect_n, 7)) else $error("dcd lvl");
   ri_level_a: assert property (lvl_p(modem_n.ring_indicator_n, 6)) else $error("ri lvl");
   cts_level_a: assert property (lvl_p(modem_n.clear_to_send_n, 4)) else $error("cts lvl");
   dsr_flag_a: assert property (flag_p(modem_n.data_set_ready_n, 1)) else $error("dsr flg");
   dcd_flag_a: assert property (flag_p(modem_n.carrier_detect_n, 3)) else $error("dcd flg");
   ri_flag_a: assert property (flag_p(modem_n.ring_indicator_n, 2)) else $error("ri flg");
   cts_flag_a: assert property (flag_p(modem_n.clear_to_send_n, 0)) else $error("cts flg");
   flag_clear_a: assert property (rd0 && quiet_reg == 3'h7 ##2 rd0 && quiet_reg == 3'h7
      |=> hrdata[3:0] == 4'h0) else $error("flags kept");
   stat_clear_a: assert property (rd8 && quiet_reg == 3'h7 |=> !irq) else $error("irq kept");
   cover property ($rose(irq));
   cover property (rd0 ##1 hrdata[3:0] != 4'h0);
   cover property (rd0 ##1 hrdata[7:4] != 4'h0);
endmodule : modem_status_inputs_chk
bind modem_status_inputs modem_status_inputs_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .modem_n, .irq);

// File: dv/tb_uart_modem_status_inputs.sv
// Testbench: modem status block over AHB-Lite with a modem model
`timescale 1ns/100ps
module tb_uart_modem_status_inputs;
   import modem_status_pkg::*;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0]  haddr, hwdata, hrdata, rd;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   modem_lines_s modem_n;
   int           error_cnt, checked;
   modem_status_inputs DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .modem_n, .irq);
   modem_model u_modem (.modem_n);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task summarize;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Bounded wait for hready, so a hung slave still ends the run
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         summarize;
      end
   endtask : wait_rdy
   // One word transfer; read data lands in rd
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask : ahb
   task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      ahb(1'b0, a, 32'h0);
      chk(nm, e, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rchk
   // Move one pin, then let the synchroniser settle
   task move(input int i, input logic v);
      u_modem.set_line(i, v);
      repeat (8) @(posedge hclk);
   endtask : move
   task t_lines;
      rchk(8'h10, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         move(i, 1'b0);
         rchk(OFF_MODEM_STATUS, 32'h10 << i, "level");
         move(i, 1'b1);
         rchk(OFF_MODEM_STATUS, 32'h1 << i, "flag");
         rchk(OFF_MODEM_STATUS, 32'h0, "cleared");
      end
      $display("t_lines done");
   endtask : t_lines
   task t_irq;
      ahb(1'b1, OFF_INTERRUPT_ENABLE, 32'h8);
      ahb(1'b1, OFF_IRQ_MASK, 32'hf);
      rchk(OFF_INTERRUPT_ENABLE, 32'h8, "enable");
      move(1, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(OFF_IRQ_STATUS, 32'h2, "irq stat");
      chk("irq clr", 32'h0, {31'h0, irq});
      move(3, 1'b0);
      rchk(OFF_IRQ_STATUS, 32'h8, "irq stat");
      ahb(1'b1, OFF_IRQ_MASK, 32'h0);
      move(2, 1'b0);
      chk("irq mask", 32'h0, {31'h0, irq});
      rchk(OFF_IRQ_STATUS, 32'h4, "irq stat");
      ahb(1'b1, OFF_INTERRUPT_ENABLE, 32'h0);
      move(1, 1'b1);
      rchk(OFF_IRQ_STATUS, 32'h0, "irq off");
      rchk(OFF_MODEM_STATUS, 32'hc2, "status");
      $display("t_irq done");
   endtask : t_irq
   initial begin
      error_cnt = 0;
      checked   = 0;
      hresetn   = 1'b0;
      hsel      = 1'b0;
      haddr     = 32'h0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = HSIZE_WORD;
      hwdata    = 32'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_lines;
      t_irq;
      summarize;
   end
endmodule : tb_uart_modem_status_inputs

// File: pkg/modem_status_pkg.sv
// Package: register map, field layout, reset values and state of the modem status block
package modem_status_pkg;

   // Bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;

   // Byte offsets of the registers
   localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_INTERRUPT_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS       = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK         = 8'h0c;

   // Modem status layout: change flags in 3:0, inverted levels in 7:4
   localparam int unsigned MSR_DELTA_LSB = 0;
   localparam int unsigned MSR_LEVEL_LSB = 4;
   localparam int unsigned LINE_CNT      = 4;

   // Interrupt enable: modem status interrupt enable bit
   localparam int unsigned IER_MODEM_BIT = 3;
   localparam int unsigned IER_W         = 8;

   // Interrupt status and mask: one sticky bit per line change
   localparam int unsigned IRQ_W = 4;

   // Reset values
   localparam logic [IER_W-1:0]    IER_RESET   = 8'h00;
   localparam logic [IRQ_W-1:0]    IRQ_RESET   = 4'h0;
   localparam logic [IRQ_W-1:0]    MASK_RESET  = 4'h0;
   localparam logic [LINE_CNT-1:0] LINES_IDLE  = 4'hf;
   localparam logic [LINE_CNT-1:0] DELTA_RESET = 4'h0;
   localparam logic [DATA_W-1:0]   RDATA_RESET = 32'h0000_0000;

   // AHB-Lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic       HRESP_OKAY = 1'b0;

   // Active-low modem lines; bit i maps to change flag i and level bit 4+i
   typedef struct packed {
      logic carrier_detect_n;
      logic ring_indicator_n;
      logic data_set_ready_n;
      logic clear_to_send_n;
   } modem_lines_s;

   // Whole state of the block
   typedef struct packed {
      logic [LINE_CNT-1:0] sync1;
      logic [LINE_CNT-1:0] sync2;
      logic [LINE_CNT-1:0] sync3;
      logic [LINE_CNT-1:0] stable;
      logic [LINE_CNT-1:0] delta;
      logic [IER_W-1:0]    interrupt_enable_reg;
      logic [IRQ_W-1:0]    irq_stat;
      logic [IRQ_W-1:0]    irq_mask;
      logic                wr_pend;
      logic [ADDR_W-1:0]   wr_addr;
      logic [DATA_W-1:0]   rdata;
   } state_s;

endpackage : modem_status_pkg

// File: verilog/modem_status_inputs.sv
// Modem status input logic with an AHB-Lite register slave and interrupt
//
// Functional notes
// - The inverted data set ready line is read back in modem status bit 5.
// - A low-to-high move of data set ready since the last status read sets bit 1.
// - The inverted carrier detect line is read back in modem status bit 7.
// - A low-to-high move of carrier detect since the last status read sets bit 3.
// - The inverted ring indicator line is read back in modem status bit 6.
// - A low-to-high move of ring indicator since the last status read sets bit 2.
// - With interrupt enable bit 3 set, any change of these lines sets interrupt status; irq rises only where mask bit i is also set.
// - Clear to send shows inverted in bit 4, and its low-to-high move sets bit 0.
//
// Register map, one word each, fields in the low bits, the rest read zero:
//   0x00 modem status, read only; a read clears change flags 3:0
//        7 carrier detect, 6 ring indicator, 5 data set ready, 4 clear to send
//        3:0 change flags in the same line order, set on pin low-to-high
//   0x04 interrupt enable, read/write; bit 3 lets line changes raise status
//   0x08 interrupt status, read only; bit i set on any change of line i
//        while enabled; a read clears it, a change in that cycle still lands
//   0x0c interrupt mask, read/write; bit i lets status bit i drive irq
//
// Bus timing: zero wait states, hresp always OKAY. Read data and read side
// effects are taken at the edge that ends the address phase; write data lands
// at the edge that ends the data phase and is forwarded to a read right behind.
//
// Pin timing: each line passes three flops and counts once stages two and
// three agree, so a pin change shows four edges later and a one-cycle glitch
// is dropped. Reset takes every line as high, so idle pins give no event.
// Limitation: pulses shorter than two cycles are never seen.
`timescale 1ns/100ps

module modem_status_inputs (
   input  wire logic                             hclk,
   input  wire logic                             hresetn,
   input  wire logic                             hsel,
   input  wire logic [31:0]                      haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hsize,
   input  wire logic [modem_status_pkg::DATA_W-1:0] hwdata,
   input  wire logic                             hready,
   output      logic                             hreadyout,
   output      logic [modem_status_pkg::DATA_W-1:0] hrdata,
   output      logic                             hresp,
   input  wire modem_status_pkg::modem_lines_s   modem_n,
   output      logic                             irq
);
   import modem_status_pkg::*;

   state_s              state_reg;
   state_s              state_next;

   logic [LINE_CNT-1:0] lines_in;
   logic [LINE_CNT-1:0] settled;
   logic [LINE_CNT-1:0] rise;
   logic [LINE_CNT-1:0] change;
   logic [ADDR_W-1:0]   addr_lo;
   logic                take;
   logic                rd_take;
   logic                wr_take;
   logic                msr_rd;
   logic                irq_rd;
   logic [IER_W-1:0]    ier_view;
   logic [IRQ_W-1:0]    mask_view;
   logic                ier_wr;
   logic                mask_wr;
   logic                chg_irq_en;
   logic [LINE_CNT-1:0] level_now;
   logic [LINE_CNT-1:0] delta_kept;
   logic [LINE_CNT-1:0] delta_next;
   logic [IRQ_W-1:0]    stat_kept;
   logic [IRQ_W-1:0]    stat_next;
   logic [DATA_W-1:0]   msr_word;
   logic [DATA_W-1:0]   ier_word;
   logic [DATA_W-1:0]   stat_word;
   logic [DATA_W-1:0]   mask_word;
   logic [DATA_W-1:0]   rd_word;

   // Pins packed into one vector in change-flag order
   assign lines_in = modem_n;

   // Address phase decode; haddr above ADDR_W is left to the fabric's hsel
   assign addr_lo = haddr[ADDR_W-1:0];
   assign take    = hsel && hready && htrans[1];
   assign rd_take = take && !hwrite;
   assign wr_take = take && hwrite && (hsize == HSIZE_WORD);
   assign msr_rd  = rd_take && (addr_lo == OFF_MODEM_STATUS);
   assign irq_rd  = rd_take && (addr_lo == OFF_IRQ_STATUS);

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = state_reg.rdata;

   // Level interrupt from the sticky status and its mask
   assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

   // Write strobes of the data phase; the address was caught one edge earlier
   assign ier_wr  = state_reg.wr_pend && (state_reg.wr_addr == OFF_INTERRUPT_ENABLE);
   assign mask_wr = state_reg.wr_pend && (state_reg.wr_addr == OFF_IRQ_MASK);

   // Views that forward a write still in its data phase to a read right behind it
   always_comb begin
      ier_view  = state_reg.interrupt_enable_reg;
      mask_view = state_reg.irq_mask;
      if (ier_wr) begin
         ier_view = hwdata[IER_W-1:0];
      end
      if (mask_wr) begin
         mask_view = hwdata[IRQ_W-1:0];
      end
   end

   // One slice per modem line: filter, edge detect and read-back level
   for (genvar g = 0; g < LINE_CNT; g++) begin : g_line
      // Stages two and three must agree, so a one-cycle glitch never counts
      assign settled[g]   = (state_reg.sync2[g] == state_reg.sync3[g])
                          ? state_reg.sync3[g] : state_reg.stable[g];
      // Pin high after low: asserted line has dropped away
      assign rise[g]      = settled[g] && !state_reg.stable[g];
      // Either direction counts for the interrupt
      assign change[g]    = settled[g] != state_reg.stable[g];
      // Read back inverted, so an asserted line reads as one
      assign level_now[g] = ~state_reg.stable[g];
   end

   // Change flags; a set in the clearing cycle survives the read
   always_comb begin
      delta_kept = state_reg.delta;
      if (msr_rd) begin
         delta_kept = DELTA_RESET;
      end
      delta_next    = delta_kept;
      delta_next[1] = delta_kept[1] | rise[1];
      delta_next[3] = delta_kept[3] | rise[3];
      delta_next[2] = delta_kept[2] | rise[2];
      delta_next[0] = delta_kept[0] | rise[0];
   end

   // Change interrupts only while the enable bit is set
   assign chg_irq_en = state_reg.interrupt_enable_reg[IER_MODEM_BIT];

   // Interrupt status: read clears, a new change wins over the clear
   always_comb begin
      stat_kept = state_reg.irq_stat;
      if (irq_rd) begin
         stat_kept = IRQ_RESET;
      end
      stat_next = stat_kept;
      if (chg_irq_en) begin
         stat_next = stat_kept | change;
      end
   end

   // Modem status word: inverted levels in 7:4, change flags in 3:0
   always_comb begin
      msr_word                            = RDATA_RESET;
      msr_word[MSR_LEVEL_LSB+1]           = level_now[1];
      msr_word[MSR_LEVEL_LSB+3]           = level_now[3];
      msr_word[MSR_LEVEL_LSB+2]           = level_now[2];
      msr_word[MSR_LEVEL_LSB+0]           = level_now[0];
      msr_word[MSR_DELTA_LSB +: LINE_CNT] = state_reg.delta;
   end

   // Narrow registers sit in the low bits, the rest reads zero
   always_comb begin
      ier_word             = RDATA_RESET;
      stat_word            = RDATA_RESET;
      mask_word            = RDATA_RESET;
      ier_word[IER_W-1:0]  = ier_view;
      stat_word[IRQ_W-1:0] = state_reg.irq_stat;
      mask_word[IRQ_W-1:0] = mask_view;
   end

   // Read mux on the address phase; unmapped offsets read as zero
   always_comb begin
      rd_word = RDATA_RESET;
      unique case (addr_lo)
         OFF_MODEM_STATUS: begin
            rd_word = msr_word;
         end
         OFF_INTERRUPT_ENABLE: begin
            rd_word = ier_word;
         end
         OFF_IRQ_STATUS: begin
            rd_word = stat_word;
         end
         OFF_IRQ_MASK: begin
            rd_word = mask_word;
         end
         default: begin
            rd_word = RDATA_RESET;
         end
      endcase
   end

   // Next state of the whole block
   always_comb begin
      state_next = state_reg;

      // Three-stage synchroniser; stage one feeds only stage two
      state_next.sync1  = lines_in;
      state_next.sync2  = state_reg.sync1;
      state_next.sync3  = state_reg.sync2;
      state_next.stable = settled;

      // Sticky flags and interrupt status
      state_next.delta    = delta_next;
      state_next.irq_stat = stat_next;

      // Data phase of a write lands here; read-only or unmapped writes drop
      if (ier_wr) begin
         state_next.interrupt_enable_reg = hwdata[IER_W-1:0];
      end
      if (mask_wr) begin
         state_next.irq_mask = hwdata[IRQ_W-1:0];
      end
      state_next.wr_pend = wr_take;
      state_next.wr_addr = addr_lo;

      // Read data registered at the address phase, stands through the data phase
      if (rd_take) begin
         state_next.rdata = rd_word;
      end
   end

   // State register; idle lines reset high so no false change at release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg.sync1    <= LINES_IDLE;
         state_reg.sync2    <= LINES_IDLE;
         state_reg.sync3    <= LINES_IDLE;
         state_reg.stable   <= LINES_IDLE;
         state_reg.delta    <= DELTA_RESET;
         state_reg.interrupt_enable_reg      <= IER_RESET;
         state_reg.irq_stat <= IRQ_RESET;
         state_reg.irq_mask <= MASK_RESET;
         state_reg.wr_pend  <= 1'b0;
         state_reg.wr_addr  <= OFF_MODEM_STATUS;
         state_reg.rdata    <= RDATA_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule : modem_status_inputs
